// *** logic/plc_command_rotation_port.sv ***
// On-command rotation port: command decode, frame packing and output FIFO
`timescale 1ns/1ps
module plc_command_rotation_port
	import plc_rotation_pkg::*;
#(
	parameter int UPDATE_PERIOD = plc_rotation_pkg::UPDATE_CYCLES
) (
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	input  wire logic [plc_rotation_pkg::CMD_W-1:0] cmd_word,
	input  wire plc_rotation_pkg::fmt_t        data_format,
	input  wire logic [2:0]                    slot_count,
	input  wire logic [31:0]                   net_float,
	input  wire logic [31:0]                   rate_float,
	input  wire logic signed [31:0]            net_disp,
	input  wire logic signed [31:0]            rate_disp,
	input  wire logic [15:0]                   division_size,
	output logic                               tx_valid,
	input  wire logic                          tx_ready,
	output logic [plc_rotation_pkg::WORD_W-1:0] tx_data,
	output logic [7:0]                         ack_value,
	output logic [plc_rotation_pkg::TAG_W-1:0] field_tag,
	output logic [5:0]                         tx_bytes,
	output logic [5:0]                         rx_bytes
);
	import plc_rotation_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================================
	// Update cycle timebase
	logic tick;
	logic tick_d;

	update_tick #(.PERIOD(UPDATE_PERIOD)) u_tick (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_d <= 1'b0;
		end else begin
			tick_d <= tick;
		end
	end

	// ==========================================================
	// Command decode and rotation
	field_t      field;
	field_t      next_field;
	logic [15:0] last_cmd;
	logic [7:0]  ack;
	logic        new_cmd;

	assign new_cmd = tick && (cmd_word != last_cmd);

	always_comb begin
		next_field = field;
		if (cmd_word == CMD_REPORT_FIRST || cmd_word == CMD_REPORT_NEXT) begin
			unique case (field)
				FIELD_IDLE: begin
					next_field = (cmd_word == CMD_REPORT_FIRST) ? FIELD_NET
						: FIELD_RATE;
				end
				FIELD_NET: begin
					next_field = FIELD_RATE;
				end
				FIELD_RATE: begin
					next_field = FIELD_NET;
				end
				default: begin
					next_field = FIELD_IDLE;
				end
			endcase
		end
	end

	// Field moves only on a changed command, never on the refresh alone
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			field    <= FIELD_IDLE;
			last_cmd <= 16'h0000;
			ack      <= ACK_RESET;
		end else if (tick) begin
			last_cmd <= cmd_word;
			if (new_cmd) begin
				field <= next_field;
				ack   <= cmd_word[7:0];
			end
		end
	end

	// ==========================================================
	// Slot sizing
	logic [2:0] slots;
	logic       is_float;
	logic [4:0] frame_words;

	assign slots    = (slot_count == 3'h0) ? 3'h1
		: (slot_count > 3'(MAX_SLOTS)) ? 3'(MAX_SLOTS) : slot_count;
	assign is_float = (data_format == FMT_FLOAT);
	assign tx_bytes = is_float ? 6'(FLT_TX_BYTES_PER_SLOT * slots)
		: 6'(INT_BYTES_PER_SLOT * slots);
	assign rx_bytes = is_float
		? 6'(FLT_RX_OVERHEAD + FLT_RX_BYTES_PER_SLOT * slots)
		: 6'(INT_BYTES_PER_SLOT * slots);
	assign frame_words = 5'(tx_bytes / 6'(WORD_BYTES));

	// ==========================================================
	// Value selection and integer conversion
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > INT_MAX) begin
			return 16'h7FFF;
		end else if (v < INT_MIN) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	logic signed [31:0] sel_disp;
	logic signed [31:0] div_q;
	logic [31:0]        sel_float;
	logic [7:0]         sel_tag;

	assign sel_disp  = (field == FIELD_RATE) ? rate_disp : net_disp;
	// Zero division size would be a calibration fault; report zero
	assign div_q     = (division_size == 16'h0000) ? 32'sd0
		: sel_disp / $signed({16'h0000, division_size});
	assign sel_float = (field == FIELD_RATE) ? rate_float
		: (field == FIELD_NET) ? net_float : 32'h0000_0000;
	assign sel_tag   = (field == FIELD_RATE) ? TAG_RATE
		: (field == FIELD_NET) ? TAG_NET : TAG_NONE;

	// ==========================================================
	// Frame snapshot and word packing
	send_t       send_state;
	logic [4:0]  word_idx;
	logic [4:0]  snap_words;
	logic        snap_float_fmt;
	logic [31:0] snap_value;
	logic [15:0] snap_int;
	logic        frame_start;
	logic        fifo_ready;
	logic        push;
	logic [15:0] push_word;
	logic        frame_done;

	// A refresh landing mid-frame is dropped rather than tearing a frame
	assign frame_start = tick_d && (send_state == SEND_IDLE);
	assign push        = (send_state == SEND_BUSY);
	assign frame_done  = push && fifo_ready && (word_idx == snap_words - 1'b1);

	// Tag, ack and value are captured on the same edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_value      <= ACK_RESET;
			field_tag      <= TAG_NONE;
			snap_value     <= 32'h0000_0000;
			snap_int       <= 16'h0000;
			snap_words     <= 5'h02;
			snap_float_fmt <= 1'b0;
		end else if (frame_start) begin
			ack_value      <= ack;
			field_tag      <= sel_tag;
			snap_value     <= sel_float;
			snap_int       <= (data_format == FMT_DIVISION) ? sat16(div_q)
				: sat16(sel_disp);
			snap_words     <= frame_words;
			snap_float_fmt <= is_float;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			send_state <= SEND_IDLE;
			word_idx   <= 5'h00;
		end else begin
			unique case (send_state)
				SEND_IDLE: begin
					if (tick_d) begin
						send_state <= SEND_BUSY;
						word_idx   <= 5'h00;
					end
				end
				SEND_BUSY: begin
					if (fifo_ready) begin
						word_idx <= word_idx + 5'h01;
						if (frame_done) begin
							send_state <= SEND_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		if (snap_float_fmt) begin
			unique case (word_idx[1:0])
				2'b00:   push_word = {ack_value, field_tag};
				2'b01:   push_word = 16'h0000;
				2'b10:   push_word = snap_value[31:16];
				default: push_word = snap_value[15:0];
			endcase
		end else begin
			push_word = word_idx[0] ? {ack_value, field_tag} : snap_int;
		end
	end

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_word),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	// ==========================================================
	// Assertions
	logic [4:0] sent;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sent <= 5'h00;
		end else if (frame_start) begin
			sent <= 5'h00;
		end else if (push && fifo_ready) begin
			sent <= sent + 5'h01;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_first;
		tick && new_cmd && cmd_word == CMD_REPORT_FIRST && field == FIELD_IDLE
			|=> field == FIELD_NET && ack == 8'h01;
	endproperty
	a_first: assert property (p_first) else $error("start not net");

	property p_next;
		tick && new_cmd && cmd_word == CMD_REPORT_NEXT && field == FIELD_NET
			|=> field == FIELD_RATE && ack == 8'h02;
	endproperty
	a_next: assert property (p_next) else $error("next not rate");

	property p_wrap;
		tick && new_cmd && cmd_word == CMD_REPORT_FIRST && field == FIELD_RATE
			|=> field == FIELD_NET && ack == 8'h01;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to net");

	property p_same_cmd;
		tick && cmd_word == last_cmd |=> $stable(field) && $stable(ack);
	endproperty
	a_same_cmd: assert property (p_same_cmd) else $error("repeat moved");

	property p_hold;
		!tick |=> $stable(field);
	endproperty
	a_hold: assert property (p_hold) else $error("field moved alone");

	property p_pair;
		frame_start |=> field_tag == $past(sel_tag)
			&& snap_value == $past(sel_float) && ack_value == $past(ack);
	endproperty
	a_pair: assert property (p_pair) else $error("tag value split");

	property p_count;
		frame_done |=> sent == snap_words;
	endproperty
	a_count: assert property (p_count) else $error("frame size wrong");

	property p_float_hi;
		push && snap_float_fmt && word_idx[1:0] == 2'b10
			|-> push_word == snap_value[31:16];
	endproperty
	a_float_hi: assert property (p_float_hi) else $error("float order");

	property p_rx_size;
		// Tied to the outgoing size, so a wrong slot count shows up too
		is_float |-> rx_bytes == 6'(FLT_RX_OVERHEAD)
			+ 6'h03 * (tx_bytes >> 2)
			&& rx_bytes >= 6'h08 && rx_bytes <= 6'h1A;
	endproperty
	a_rx_size: assert property (p_rx_size) else $error("rx size wrong");

	c_rotate: cover property (field == FIELD_NET ##[1:1000] field == FIELD_RATE
		##[1:1000] field == FIELD_NET);
	c_float_frame: cover property (frame_done && snap_float_fmt);
	c_full: cover property (push && !fifo_ready);
endmodule

// *** logic/plc_rotation_pkg.sv ***
// Shared constants and types for the command rotation port
package plc_rotation_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int UPDATE_MS     = 60;
	localparam int UPDATE_CYCLES = UPDATE_MS * (CLK_HZ / 1000);

	// ==========================================================
	// Command word and answer codes
	localparam int          CMD_W            = 16;
	localparam int          TAG_W            = 8;
	localparam logic [15:0] CMD_REPORT_FIRST = 16'h0001;
	localparam logic [15:0] CMD_REPORT_NEXT  = 16'h0002;
	localparam logic [7:0]  TAG_NET          = 8'h01;
	localparam logic [7:0]  TAG_RATE         = 8'h06;
	localparam logic [7:0]  TAG_NONE         = 8'h1E;
	localparam logic [7:0]  ACK_RESET        = 8'h00;

	// ==========================================================
	// Data formats and slot sizes
	localparam int WORD_W                = 16;
	localparam int FLOAT_W               = 32;
	localparam int MAX_SLOTS             = 4;
	localparam int FIFO_DEPTH            = 32;
	localparam int INT_BYTES_PER_SLOT    = 4;
	localparam int FLT_TX_BYTES_PER_SLOT = 8;
	localparam int FLT_RX_OVERHEAD       = 2;
	localparam int FLT_RX_BYTES_PER_SLOT = 6;
	localparam int WORD_BYTES            = 2;
	localparam logic signed [31:0] INT_MIN = -32'sd32768;
	localparam logic signed [31:0] INT_MAX = 32'sd32767;

	typedef enum logic [1:0] {
		FMT_INTEGER  = 2'b00,
		FMT_DIVISION = 2'b01,
		FMT_FLOAT    = 2'b10,
		FMT_SPARE    = 2'b11
	} fmt_t;

	typedef enum logic [1:0] {
		FIELD_IDLE = 2'b00,
		FIELD_NET  = 2'b01,
		FIELD_RATE = 2'b10
	} field_t;

	typedef enum logic {
		SEND_IDLE = 1'b0,
		SEND_BUSY = 1'b1
	} send_t;
endpackage

// *** logic/update_tick.sv ***
// Interface update cycle timebase: one-cycle pulse every PERIOD clocks
`timescale 1ns/1ps
module update_tick #(
	parameter int PERIOD = 600000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [31:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (count == 32'(PERIOD - 1)) begin
			count <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule

// *** logic/word_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				fill <= fill + 1'b1;
			end else if (pop && !push) begin
				fill <= fill - 1'b1;
			end
		end
	end
endmodule

// *** bench/tx_sink.sv ***
// Receive side of the controller: takes frame words with random pauses
`timescale 1ns/1ps
module tx_sink (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic hold,
	output logic      tx_ready
);
	logic [7:0] lfsr;

	// ==========================================================
	// Ready pattern
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr     <= 8'hA5;
			tx_ready <= 1'b0;
		end else begin
			lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			// Pauses mimic a busy scan; hold lets the FIFO fill up
			tx_ready <= !hold && (lfsr[0] | lfsr[1]);
		end
	end
endmodule

// *** bench/plc_command_rotation_port_tb_top.sv ***
// Self-checking bench for the command rotation port
`timescale 1ns/1ps
module plc_command_rotation_port_tb_top;
	import plc_rotation_pkg::*;
	localparam int PERIOD = 50;
	logic               ref_clk;
	logic               reset_n;
	logic [15:0]        cmd_word;
	fmt_t               data_format;
	logic [2:0]         slot_count;
	logic [31:0]        net_float;
	logic [31:0]        rate_float;
	logic signed [31:0] net_disp;
	logic signed [31:0] rate_disp;
	logic [15:0]        division_size;
	logic               tx_valid;
	logic               tx_ready;
	logic [15:0]        tx_data;
	logic [7:0]         ack_value;
	logic [7:0]         field_tag;
	logic [5:0]         tx_bytes;
	logic [5:0]         rx_bytes;
	logic               hold;
	logic [31:0]        seed;
	logic [15:0]        seen[$];
	logic [15:0]        last_cmd;
	int                 field;
	int                 err_total;
	int                 checks;

	// ==========================================================
	// Design and partner
	plc_command_rotation_port #(.UPDATE_PERIOD(PERIOD)) dut (
		.ref_clk       (ref_clk),
		.reset_n       (reset_n),
		.cmd_word      (cmd_word),
		.data_format   (data_format),
		.slot_count    (slot_count),
		.net_float     (net_float),
		.rate_float    (rate_float),
		.net_disp      (net_disp),
		.rate_disp     (rate_disp),
		.division_size (division_size),
		.tx_valid      (tx_valid),
		.tx_ready      (tx_ready),
		.tx_data       (tx_data),
		.ack_value     (ack_value),
		.field_tag     (field_tag),
		.tx_bytes      (tx_bytes),
		.rx_bytes      (rx_bytes)
	);
	tx_sink sink (
		.clk      (ref_clk),
		.rst_n    (reset_n),
		.hold     (hold),
		.tx_ready (tx_ready)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] sat16(input int v);
		if (v > 32767) return 16'h7FFF;
		if (v < -32768) return 16'h8000;
		return v[15:0];
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			seen.push_back(tx_data);
		end
	end

	// ==========================================================
	// One command step with fresh inputs and a frame check
	task automatic run_step(input logic [15:0] cmd, input logic stall);
		logic [31:0] r;
		logic [1:0]  fm;
		logic [2:0]  sc;
		logic [31:0] fv;
		logic [15:0] hdr;
		logic [15:0] v16;
		logic [7:0]  tag;
		int          n;
		int          nw;
		int          base;
		int          cnt;
		int          d;
		r  = rnd();
		fm = stall ? 2'b10 : r[1:0];
		sc = stall ? 3'd4 : r[4:2];
		@(posedge ref_clk);
		cmd_word      <= cmd;
		data_format   <= fmt_t'(fm);
		slot_count    <= sc;
		net_float     <= rnd();
		rate_float    <= rnd();
		r = rnd();
		net_disp      <= 32'(signed'({{15{r[16]}}, r[16:0]}));
		rate_disp     <= 32'(signed'({{15{r[31]}}, r[31:15]}));
		division_size <= (r[2:0] == 3'd0) ? 16'h0000 : {4'h0, r[27:16]};
		hold          <= stall;
		if (cmd !== last_cmd && (cmd == 16'd1 || cmd == 16'd2)) begin
			field = (field == 0) ? int'(cmd) : 3 - field;
		end
		last_cmd = cmd;
		tag = (field == 1) ? TAG_NET : (field == 2) ? TAG_RATE : TAG_NONE;
		// Controller waits for the acknowledge before moving on
		cnt = 0;
		while ((ack_value !== cmd[7:0] || field_tag !== tag) && cnt < 400) begin
			@(posedge ref_clk);
			cnt++;
		end
		check(ack_value, cmd[7:0]);
		check(field_tag, tag);
		// Several refreshes must not move the field
		repeat (150) @(posedge ref_clk);
		check(field_tag, tag);
		check(ack_value, cmd[7:0]);
		@(posedge ref_clk);
		hold <= 1'b0;
		cnt = 0;
		d   = 0;
		while (d < 4 && cnt < 600) begin
			@(posedge ref_clk);
			cnt++;
			d = (tx_valid === 1'b0) ? d + 1 : 0;
		end
		// A stream that never goes quiet counts as a mismatch
		check(d, 4);
		n   = (sc == 3'd0) ? 1 : (sc > 3'd4) ? 4 : int'(sc);
		hdr = {cmd[7:0], tag};
		// Value chosen by the returned tag, as the controller does
		fv = (tag == TAG_RATE) ? rate_float : net_float;
		d  = (tag == TAG_RATE) ? int'(rate_disp) : int'(net_disp);
		if (fm == 2'b01) begin
			// Controller multiplies this count back by the size
			d = (division_size == 16'h0000) ? 0 : d / int'(division_size);
		end
		v16 = sat16(d);
		if (fm == 2'b10) begin
			check(tx_bytes, 8 * n);
			check(rx_bytes, 2 + 6 * n);
		end else begin
			check(tx_bytes, 4 * n);
			check(rx_bytes, 4 * n);
		end
		nw   = int'(tx_bytes) / 2;
		base = seen.size() - nw;
		check(base >= 0, 1'b1);
		for (int s = 0; s < n && base >= 0; s++) begin
			if (fm == 2'b10) begin
				check(seen[base + 4 * s], hdr);
				check(seen[base + 4 * s + 1], 16'h0000);
				check(seen[base + 4 * s + 2], fv[31:16]);
				check(seen[base + 4 * s + 3], fv[15:0]);
			end else if (field != 0) begin
				check(seen[base + 2 * s], v16);
				check(seen[base + 2 * s + 1], hdr);
			end
		end
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = !ref_clk;
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		logic [15:0] cmds[10];
		cmds = '{16'd1, 16'd1, 16'd2, 16'd1, 16'd2, 16'd5, 16'd1,
			16'd2, 16'd2, 16'd1};
		seed          = 32'h1DEB;
		err_total     = 0;
		checks        = 0;
		field         = 0;
		last_cmd      = 16'h0000;
		reset_n       = 1'b0;
		hold          = 1'b0;
		cmd_word      = 16'h0000;
		data_format   = FMT_FLOAT;
		slot_count    = 3'd1;
		net_float     = 32'h0000_0000;
		rate_float    = 32'h0000_0000;
		net_disp      = 32'sd0;
		rate_disp     = 32'sd0;
		division_size = 16'h0001;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			run_step(cmds[i], i == 4);
			$display("step %0d command %0d finished", i, cmds[i]);
		end
		tally_and_finish();
	end
endmodule
